/* File: design/osp_serial_slave.sv */
// Two-wire slave port with register words and EEPROM commit control
`timescale 1ns/10ps
`default_nettype none
`include "osp_defines.svh"
module osp_serial_slave import osp_pkg::*; #(
    parameter int unsigned EE_WRITE_CYCLES = `OSP_EE_WRITE_CYCLES
) (
    // System clock domain
    input wire logic clk,
    input wire logic srst,
    // Serial link
    input wire logic link_clk,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe,
    // Device side
    input wire logic power_down_i,
    output osp_words_t nv_words,
    output logic ee_busy,
    output logic ee_write_pulse
);

    generate
        if (EE_WRITE_CYCLES < 1) begin : g_bad
            $error("EE_WRITE_CYCLES must be at least one");
        end
    endgenerate

    // ---------------------------------------------------------------------------
    // Link domain reset and input synchronisers
    // ---------------------------------------------------------------------------
    logic lrst_m_q, lrst;
    logic scl_m_q, scl_s_q, scl_p_q;
    logic sda_m_q, sda_s_q, sda_p_q;
    logic pd_m_q, pd_s_q;
    logic ack_m_q, ack_s_q;
    logic req_q;
    logic ack_tog_q;

    always_ff @(posedge link_clk) begin
        lrst_m_q <= srst;
        lrst <= lrst_m_q;
    end

    always_ff @(posedge link_clk) begin
        if (lrst) begin
            scl_m_q <= 1'b1;
            scl_s_q <= 1'b1;
            scl_p_q <= 1'b1;
            sda_m_q <= 1'b1;
            sda_s_q <= 1'b1;
            sda_p_q <= 1'b1;
            pd_m_q <= 1'b0;
            pd_s_q <= 1'b0;
            ack_m_q <= 1'b0;
            ack_s_q <= 1'b0;
        end else begin
            scl_m_q <= scl_i;
            scl_s_q <= scl_m_q;
            scl_p_q <= scl_s_q;
            sda_m_q <= sda_i;
            sda_s_q <= sda_m_q;
            sda_p_q <= sda_s_q;
            pd_m_q <= power_down_i;
            pd_s_q <= pd_m_q;
            ack_m_q <= ack_tog_q;
            ack_s_q <= ack_m_q;
        end
    end

    // ---------------------------------------------------------------------------
    // Bus condition decode
    // ---------------------------------------------------------------------------
    wire scl_rise = scl_s_q & ~scl_p_q;
    wire scl_fall = ~scl_s_q & scl_p_q;
    wire scl_high = scl_s_q & scl_p_q;
    wire start_det = scl_high & sda_p_q & ~sda_s_q;
    wire stop_det = scl_high & ~sda_p_q & sda_s_q;

    // ---------------------------------------------------------------------------
    // Link state
    // ---------------------------------------------------------------------------
    osp_state_t state_q;
    osp_kind_t kind_q;
    logic [3:0] cnt_q;
    logic [7:0] rx_q, tx_q, cmd_q, msb_q;
    logic rw_q, idx_q, drive_q, mack_q, dirty_q, want_q;
    osp_words_t words_q, snap_q;

    wire link_busy = req_q ^ ack_s_q;
    wire wc = words_q.bus[`OSP_WC_BIT];
    wire [2:0] dev_sel = words_q.bus[`OSP_SEL_MSB:`OSP_SEL_LSB];

    // Byte decode at the falling edge that closes the eighth bit
    wire byte_end = (state_q == OSP_RX) & scl_fall & (cnt_q == 4'd8);
    wire ctrl_match = (rx_q[7:4] == `OSP_TYPE_CODE) & (rx_q[3:1] == dev_sel)
        & ~link_busy & ~pd_s_q;
    wire cmd_is_word = (cmd_q == `OSP_CMD_DIV) | (cmd_q == `OSP_CMD_MUX);
    wire cmd_ok = (rx_q == `OSP_CMD_DIV) | (rx_q == `OSP_CMD_MUX)
        | (rx_q == `OSP_CMD_BUS) | (rx_q == `OSP_CMD_COMMIT);
    wire data_ok = ~rw_q & (cmd_q != `OSP_CMD_COMMIT);
    wire byte_ack = (kind_q == OSP_K_CTRL) ? ctrl_match
        : (kind_q == OSP_K_CMD) ? cmd_ok : data_ok;
    wire data_wr = byte_end & (kind_q == OSP_K_DATA) & data_ok;
    wire word_done = data_wr & cmd_is_word & idx_q;
    wire commit_bus = data_wr & (cmd_q == `OSP_CMD_BUS);
    wire commit_cmd = byte_end & (kind_q == OSP_K_CMD) & ~rw_q
        & (rx_q == `OSP_CMD_COMMIT) & wc;
    wire commit_end = (start_det | stop_det) & dirty_q & ~wc;
    wire set_want = commit_bus | commit_cmd | commit_end;
    wire launch = want_q & ~link_busy;

    // Byte returned to the master for a given half of the selected word
    function automatic logic [7:0] osp_sel_byte(input logic [7:0] cmd, input logic lo,
        input osp_words_t w);
        logic [7:0] b;
        b = 8'h00;
        if (cmd == `OSP_CMD_DIV) begin
            b = lo ? w.div[7:0] : w.div[15:8];
        end else if (cmd == `OSP_CMD_MUX) begin
            b = lo ? w.output_select_word[7:0] : w.output_select_word[15:8];
        end else if (cmd == `OSP_CMD_BUS) begin
            b = w.bus;
        end
        return b;
    endfunction

    wire [7:0] tx_cur = osp_sel_byte(cmd_q, idx_q, words_q);
    wire [7:0] tx_nxt = osp_sel_byte(cmd_q, ~idx_q, words_q);

    // ---------------------------------------------------------------------------
    // Bit and byte engine
    // ---------------------------------------------------------------------------
    always_ff @(posedge link_clk) begin
        if (lrst) begin
            state_q <= OSP_IDLE;
            kind_q <= OSP_K_CTRL;
            cnt_q <= 4'h0;
            rx_q <= 8'h00;
            tx_q <= 8'h00;
            rw_q <= 1'b0;
            drive_q <= 1'b0;
            mack_q <= 1'b0;
        end else if (start_det) begin
            state_q <= OSP_RX;
            kind_q <= OSP_K_CTRL;
            cnt_q <= 4'h0;
            drive_q <= 1'b0;
        end else if (stop_det) begin
            state_q <= OSP_IDLE;
            drive_q <= 1'b0;
        end else begin
            unique case (state_q)
                OSP_IDLE: begin
                    drive_q <= 1'b0;
                end
                OSP_RX: begin
                    if (scl_rise) begin
                        rx_q <= {rx_q[6:0], sda_s_q};
                        cnt_q <= cnt_q + 4'd1;
                    end else if (byte_end) begin
                        drive_q <= byte_ack;
                        state_q <= byte_ack ? OSP_ACK : OSP_IDLE;
                        if (kind_q == OSP_K_CTRL) begin
                            rw_q <= rx_q[0];
                            kind_q <= rx_q[0] ? OSP_K_DATA : OSP_K_CMD;
                        end else begin
                            kind_q <= OSP_K_DATA;
                        end
                    end
                end
                OSP_ACK: begin
                    if (scl_fall) begin
                        cnt_q <= 4'h0;
                        if (rw_q) begin
                            tx_q <= tx_cur;
                            drive_q <= ~tx_cur[7];
                            state_q <= OSP_TX;
                        end else begin
                            drive_q <= 1'b0;
                            state_q <= OSP_RX;
                        end
                    end
                end
                OSP_TX: begin
                    if (scl_rise) begin
                        cnt_q <= cnt_q + 4'd1;
                    end else if (scl_fall) begin
                        if (cnt_q == 4'd8) begin
                            drive_q <= 1'b0;
                            state_q <= OSP_TXACK;
                        end else begin
                            tx_q <= {tx_q[6:0], 1'b0};
                            drive_q <= ~tx_q[6];
                        end
                    end
                end
                OSP_TXACK: begin
                    if (scl_rise) begin
                        mack_q <= ~sda_s_q;
                    end else if (scl_fall) begin
                        cnt_q <= 4'h0;
                        if (mack_q) begin
                            tx_q <= tx_nxt;
                            drive_q <= ~tx_nxt[7];
                            state_q <= OSP_TX;
                        end else begin
                            drive_q <= 1'b0;
                            state_q <= OSP_IDLE;
                        end
                    end
                end
            endcase
        end
    end

    // ---------------------------------------------------------------------------
    // Register words and commit requests
    // ---------------------------------------------------------------------------
    always_ff @(posedge link_clk) begin
        if (lrst) begin
            words_q <= '{div: `OSP_DIV_RESET, output_select_word: `OSP_MUX_RESET, bus: `OSP_BUS_RESET};
            cmd_q <= 8'h00;
            msb_q <= 8'h00;
            idx_q <= 1'b0;
        end else if (byte_end & byte_ack & (kind_q == OSP_K_CMD)) begin
            cmd_q <= rx_q;
            idx_q <= 1'b0;
        end else if (data_wr) begin
            idx_q <= ~idx_q;
            if (cmd_is_word & ~idx_q) begin
                msb_q <= rx_q;
            end
            if (word_done & (cmd_q == `OSP_CMD_DIV)) begin
                words_q.div <= {msb_q, rx_q};
            end
            if (word_done & (cmd_q == `OSP_CMD_MUX)) begin
                words_q.output_select_word <= {msb_q, rx_q};
            end
            if (commit_bus) begin
                words_q.bus <= {4'h0, rx_q[`OSP_BUS_USED_MSB:0]};
            end
        end else if ((state_q == OSP_TXACK) & scl_fall & mack_q) begin
            idx_q <= ~idx_q;
        end
    end

    always_ff @(posedge link_clk) begin
        if (lrst) begin
            dirty_q <= 1'b0;
            want_q <= 1'b0;
            req_q <= 1'b0;
            snap_q <= '{div: `OSP_DIV_RESET, output_select_word: `OSP_MUX_RESET, bus: `OSP_BUS_RESET};
        end else begin
            dirty_q <= word_done | (dirty_q & ~(start_det | stop_det | commit_bus));
            want_q <= set_want | (want_q & ~launch);
            if (launch) begin
                snap_q <= words_q;
                req_q <= ~req_q;
            end
        end
    end

    assign sda_o = 1'b0;
    assign sda_oe = drive_q;

    // ---------------------------------------------------------------------------
    // System domain: EEPROM write timing
    // ---------------------------------------------------------------------------
    logic req_m_q, req_s_q, req_p_q, busy_q, pulse_q;
    logic [31:0] timer_q;
    osp_words_t nv_q;

    wire req_ev = req_s_q ^ req_p_q;
    wire timer_end = busy_q & (timer_q == 32'd1);

    always_ff @(posedge clk) begin
        if (srst) begin
            req_m_q <= 1'b0;
            req_s_q <= 1'b0;
            req_p_q <= 1'b0;
        end else begin
            req_m_q <= req_q;
            req_s_q <= req_m_q;
            req_p_q <= req_s_q;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            busy_q <= 1'b0;
            timer_q <= 32'h0;
            ack_tog_q <= 1'b0;
            pulse_q <= 1'b0;
            nv_q <= '{div: `OSP_DIV_RESET, output_select_word: `OSP_MUX_RESET, bus: `OSP_BUS_RESET};
        end else begin
            pulse_q <= req_ev;
            if (req_ev) begin
                nv_q <= snap_q;
                busy_q <= 1'b1;
                timer_q <= 32'(EE_WRITE_CYCLES);
            end else if (timer_end) begin
                busy_q <= 1'b0;
                timer_q <= 32'h0;
                ack_tog_q <= ~ack_tog_q;
            end else if (busy_q) begin
                timer_q <= timer_q - 32'd1;
            end
        end
    end

    assign nv_words = nv_q;
    assign ee_busy = busy_q;
    assign ee_write_pulse = pulse_q;

endmodule
`default_nettype wire

/* File: design/osp_defines.svh */
// Constants of the oscillator serial slave port: codes, field positions, reset values, timing
// Behaviour
// - Three device-select bits form the low address part; factory value 000.
// - With write-defer clear, commit registers to EEPROM after each write command that completes a word.
// - With write-defer set, commit only on the EEPROM commit command or an interface-setup write.
// - Writing the interface-setup word always commits all three words at once.
// - SDA falling while SCL high is START; the slave detects it.
// - SDA rising while SCL high is STOP; the slave detects it.
// - SDA changes only while SCL low; one clock pulse per bit.
// - Bytes of eight bits, each followed by an acknowledge bit.
// - Works with both 100 kHz and 400 kHz serial clocks.
// - Acknowledger holds SDA low across the high phase of the ninth pulse.
// - While EEPROM writes, refuse every request; resume once the write ends.
// - Master NACKs the last read byte; slave then releases SDA high.
// - A repeated START ends the transfer and starts a fresh one.
// - Control byte: type code, select bits, direction; ACK only on full match.
// - Direction one reads, direction zero writes.
// - Select bits are programmable over the bus and kept in EEPROM.
// - Write: control byte, command byte, data; slave ACKs control and command.
// - Command 01 accesses the divider word.
// - Command 02 accesses the output-select word.
// - Command 0D accesses the interface-setup word.
// - Command 3F copies all three words to EEPROM when write-defer is set.
// - No programming is accepted while in power-down.
`ifndef OSP_DEFINES_SVH
`define OSP_DEFINES_SVH

// ---------------------------------------------------------------------------
// Control byte and commands
// ---------------------------------------------------------------------------
// Type code value is arbitrary
`define OSP_TYPE_CODE 4'h6
`define OSP_CMD_DIV 8'h01
`define OSP_CMD_MUX 8'h02
`define OSP_CMD_BUS 8'h0d
`define OSP_CMD_COMMIT 8'h3f

// ---------------------------------------------------------------------------
// Interface-setup word fields
// ---------------------------------------------------------------------------
`define OSP_WC_BIT 3
`define OSP_SEL_MSB 2
`define OSP_SEL_LSB 0
`define OSP_BUS_USED_MSB 3

// ---------------------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------------------
`define OSP_DIV_RESET 16'h0000
`define OSP_MUX_RESET 16'h1800
`define OSP_BUS_RESET 8'h00

// ---------------------------------------------------------------------------
// Timing
// ---------------------------------------------------------------------------
`define OSP_CLK_MHZ 25
`define OSP_EE_WRITE_US 10000
`define OSP_EE_WRITE_CYCLES (`OSP_EE_WRITE_US * `OSP_CLK_MHZ)

`endif

/* File: design/osp_pkg.sv */
// Types of the oscillator serial slave port
`default_nettype none
package osp_pkg;

    typedef struct packed {
        logic [15:0] div;
        logic [15:0] output_select_word;
        logic [7:0] bus;
    } osp_words_t;

    typedef enum logic [2:0] {
        OSP_IDLE,
        OSP_RX,
        OSP_ACK,
        OSP_TX,
        OSP_TXACK
    } osp_state_t;

    typedef enum logic [1:0] {
        OSP_K_CTRL,
        OSP_K_CMD,
        OSP_K_DATA
    } osp_kind_t;

endpackage
`default_nettype wire

/* File: sim/osp_serial_slave_monitor.sv */
// Concurrent checks on the ports of the serial slave port
`timescale 1ns/10ps
`default_nettype none
`include "osp_defines.svh"
module osp_serial_slave_monitor import osp_pkg::*; #(
    parameter int unsigned EE_WRITE_CYCLES = 20
) (
    // Clocks and reset
    input wire logic clk,
    input wire logic srst,
    input wire logic link_clk,
    // Serial link
    input wire logic scl_i,
    input wire logic sda_i,
    input wire logic sda_o,
    input wire logic sda_oe,
    // Device side
    input wire logic power_down_i,
    input wire osp_words_t nv_words,
    input wire logic ee_busy,
    input wire logic ee_write_pulse
);
    logic [31:0] busy_cnt_q;
    always_ff @(posedge clk) begin
        if (srst || !ee_busy) begin
            busy_cnt_q <= '0;
        end else begin
            busy_cnt_q <= busy_cnt_q + 32'h1;
        end
    end
    sequence s_commit;
        ee_write_pulse ##[0:1] ee_busy;
    endsequence
    sequence s_scl_low;
        !scl_i ##1 !scl_i;
    endsequence
    AST_SDA_O_ZERO: assert property (@(posedge link_clk) disable iff (srst) sda_o == 1'b0)
        else $error("sda_o not low");
    AST_OE_SCL_LOW: assert property (@(posedge link_clk) disable iff (srst)
        $changed(sda_oe) |-> !$past(scl_i, 2) ##0 s_scl_low)
        else $error("sda_oe moved outside scl low phase");
    AST_RESET_VAL: assert property (@(posedge clk) disable iff (srst) $fell(srst) |->
        nv_words == {`OSP_DIV_RESET, `OSP_MUX_RESET, `OSP_BUS_RESET} && !ee_busy)
        else $error("reset values wrong");
    AST_PULSE_ONE: assert property (@(posedge clk) disable iff (srst)
        ee_write_pulse |=> !ee_write_pulse)
        else $error("commit pulse longer than one cycle");
    AST_PULSE_BUSY: assert property (@(posedge clk) disable iff (srst)
        ee_write_pulse |-> s_commit)
        else $error("commit without busy");
    AST_NV_AT_PULSE: assert property (@(posedge clk) disable iff (srst)
        $changed(nv_words) |-> ee_write_pulse || $past(ee_write_pulse))
        else $error("nv words changed without commit");
    AST_BUSY_LEN: assert property (@(posedge clk) disable iff (srst)
        $fell(ee_busy) |-> busy_cnt_q == EE_WRITE_CYCLES)
        else $error("busy length wrong");
    AST_NO_PULSE_BUSY: assert property (@(posedge clk) disable iff (srst)
        ee_busy && $past(ee_busy) |-> !ee_write_pulse)
        else $error("commit while busy");
    AST_BUS_RSVD: assert property (@(posedge clk) disable iff (srst)
        nv_words.bus[7:4] == 4'h0)
        else $error("reserved bus bits set");
endmodule
bind osp_serial_slave osp_serial_slave_monitor #(.EE_WRITE_CYCLES(EE_WRITE_CYCLES))
    osp_serial_slave_monitor_inst (.clk(clk), .srst(srst), .link_clk(link_clk),
    .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe),
    .power_down_i(power_down_i), .nv_words(nv_words), .ee_busy(ee_busy),
    .ee_write_pulse(ee_write_pulse));
`default_nettype wire

/* File: sim/osp_master_model.sv */
// Two-wire bus master model making SCL and driving SDA open-drain
`timescale 1ns/10ps
`default_nettype none
module osp_master_model (
    // Bus lines
    output logic scl,
    output logic sda_drv,
    input wire logic sda
);
    int half_ns = 1250; // Fast mode by default
    initial begin
        scl = 1'b1; // Only the master clocks; idles high
        sda_drv = 1'b0;
    end
    task automatic clock_bit(input logic drive, output logic seen);
        #(half_ns / 2) sda_drv = drive; // Data moves only while SCL low
        #(half_ns / 2) scl = 1'b1;
        #(half_ns / 2) seen = sda;
        #(half_ns / 2) scl = 1'b0;
    endtask
    task automatic start();
        #(half_ns / 2) sda_drv = 1'b0;
        #(half_ns / 2) scl = 1'b1;
        #(half_ns / 2) sda_drv = 1'b1;
        #(half_ns / 2) scl = 1'b0;
    endtask
    task automatic stop();
        #(half_ns / 2) sda_drv = 1'b1;
        #(half_ns / 2) scl = 1'b1;
        #(half_ns / 2) sda_drv = 1'b0;
        #(half_ns / 2);
    endtask
    task automatic put_byte(input logic [7:0] b, output logic ack);
        logic seen;
        for (int i = 7; i >= 0; i--) begin
            clock_bit(!b[i], seen);
        end
        clock_bit(1'b0, seen); // Ninth pulse for the acknowledge
        ack = !seen;
    endtask
    task automatic get_byte(input logic last, output logic [7:0] b);
        logic seen;
        for (int i = 7; i >= 0; i--) begin
            clock_bit(1'b0, seen);
            b[i] = seen;
        end
        clock_bit(!last, seen);
    endtask
endmodule
`default_nettype wire

/* File: sim/oscillator_serial_slave_port_tb_top.sv */
// Self-checking bench of the oscillator serial slave port
`timescale 1ns/10ps
`default_nettype none
`include "osp_defines.svh"
module oscillator_serial_slave_port_tb_top import osp_pkg::*; ;
    localparam int unsigned EE_CYC = 1000;
    logic clk = 1'b0, link_clk = 1'b0, srst = 1'b1, pd = 1'b0;
    logic scl, m_drv, sda_oe, sda_o, ee_busy, ee_write_pulse, ack;
    wire logic sda = !(sda_oe | m_drv);
    osp_words_t nv_words, live, exp_nv;
    int n_errors = 0, num_checks = 0, n_pulses = 0, p0 = 0;
    logic [7:0] rb;
    logic [7:0] bad [3];
    logic [15:0] w;
    logic [2:0] cur_sel = 3'h0, s;
    initial forever #20 clk = !clk;
    initial begin
        #7;
        forever #15 link_clk = !link_clk;
    end
    always @(posedge clk) if (ee_write_pulse === 1'b1) n_pulses++;
    osp_serial_slave #(.EE_WRITE_CYCLES(EE_CYC)) osp_serial_slave_inst (.clk(clk),
        .srst(srst), .link_clk(link_clk), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
        .sda_oe(sda_oe), .power_down_i(pd), .nv_words(nv_words), .ee_busy(ee_busy),
        .ee_write_pulse(ee_write_pulse));
    osp_master_model osp_master_model_inst (.scl(scl), .sda_drv(m_drv), .sda(sda));
    task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
        num_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    function automatic logic [7:0] ctrl(input logic [2:0] sel, input logic dir);
        return {`OSP_TYPE_CODE, sel, dir};
    endfunction
    function automatic logic [7:0] exp_rd(input logic [7:0] c, input logic [15:0] v, input int i);
        return (c == `OSP_CMD_BUS || i % 2 == 1) ? v[7:0] : v[15:8];
    endfunction
    task automatic go();
        osp_master_model_inst.start();
    endtask
    task automatic send(input logic [7:0] b, input logic exp);
        osp_master_model_inst.put_byte(b, ack);
        check(ack, exp, "ack");
    endtask
    task automatic wr(input logic [7:0] c, input logic [15:0] v, input int n,
                      input logic a_ctrl, input logic a_cmd);
        p0 = n_pulses;
        go();
        send(ctrl(cur_sel, 1'b0), a_ctrl);
        if (a_ctrl) begin
            send(c, a_cmd);
            for (int i = 0; i < n; i++) begin
                send(v[(n - 1 - i) * 8 +: 8], a_cmd);
            end
        end
        osp_master_model_inst.stop();
    endtask
    task automatic rd(input logic [7:0] c, input logic [15:0] v, input int n);
        go();
        send(ctrl(cur_sel, 1'b0), 1'b1);
        send(c, 1'b1);
        go();
        send(ctrl(cur_sel, 1'b1), 1'b1);
        for (int i = 0; i < n; i++) begin
            osp_master_model_inst.get_byte(i == n - 1, rb);
            check(rb, exp_rd(c, v, i), "read byte");
        end
        check(sda, 1'b1, "sda after nack");
        osp_master_model_inst.stop();
    endtask
    task automatic wait_commit(input logic exp);
        repeat (EE_CYC + 200) @(negedge clk);
        if (exp) exp_nv = live;
        check(16'(n_pulses - p0), exp, "commits");
        check(nv_words.div, exp_nv.div, "nv div");
        check(nv_words.output_select_word, exp_nv.output_select_word, "nv mux");
        check({8'h00, nv_words.bus}, {8'h00, exp_nv.bus}, "nv bus");
    endtask
    initial begin
        #3600000;
        n_errors++;
        $display("unexpected at %0t: watchdog", $time);
        finish_test();
    end
    initial begin
        live = {`OSP_DIV_RESET, `OSP_MUX_RESET, `OSP_BUS_RESET};
        exp_nv = live;
        void'($urandom(39444));
        repeat (4) @(negedge clk);
        srst = 1'b0;
        repeat (10) @(negedge clk);
        wait_commit(1'b0);
        rd(`OSP_CMD_DIV, live.div, 2);
        rd(`OSP_CMD_MUX, live.output_select_word, 3);
        rd(`OSP_CMD_BUS, {8'h00, live.bus}, 2);
        $display("test reset done");
        w = 16'($urandom());
        wr(`OSP_CMD_DIV, w, 2, 1'b1, 1'b1);
        live.div = w;
        go();
        send(ctrl(cur_sel, 1'b0), 1'b0);
        osp_master_model_inst.stop();
        wait_commit(1'b1);
        rd(`OSP_CMD_DIV, live.div, 2);
        wr(`OSP_CMD_MUX, 16'h00a5, 1, 1'b1, 1'b1);
        wait_commit(1'b0);
        w = 16'($urandom());
        wr(`OSP_CMD_MUX, w, 2, 1'b1, 1'b1);
        live.output_select_word = w;
        wait_commit(1'b1);
        $display("test auto commit done");
        bad = '{8'h00, 8'h3e, 8'h03 + 8'($urandom_range(9))};
        foreach (bad[i]) wr(bad[i], 16'($urandom()), 2, 1'b1, 1'b0);
        wait_commit(1'b0);
        go();
        send({`OSP_TYPE_CODE ^ 4'h1, cur_sel, 1'b0}, 1'b0);
        osp_master_model_inst.stop();
        @(negedge clk) pd = 1'b1;
        wr(`OSP_CMD_DIV, 16'($urandom()), 2, 1'b0, 1'b0);
        @(negedge clk) pd = 1'b0;
        wait_commit(1'b0);
        $display("test refusals done");
        s = 3'($urandom_range(7, 1));
        wr(`OSP_CMD_BUS, {8'h00, 4'h0, 1'b1, s}, 1, 1'b1, 1'b1);
        live.bus = {4'h0, 1'b1, s};
        wait_commit(1'b1);
        go();
        send(ctrl(cur_sel, 1'b0), 1'b0);
        osp_master_model_inst.stop();
        cur_sel = s;
        w = 16'($urandom());
        wr(`OSP_CMD_DIV, w, 2, 1'b1, 1'b1);
        live.div = w;
        wait_commit(1'b0);
        wr(`OSP_CMD_COMMIT, 16'h0000, 0, 1'b1, 1'b1);
        wait_commit(1'b1);
        $display("test defer done");
        go();
        send(ctrl(cur_sel, 1'b0), 1'b1);
        send(`OSP_CMD_DIV, 1'b1);
        send(8'h5a, 1'b1);
        rd(`OSP_CMD_DIV, live.div, 2);
        osp_master_model_inst.half_ns = 5000;
        rd(`OSP_CMD_MUX, live.output_select_word, 2);
        $display("test restart and slow mode done");
        finish_test();
    end
endmodule
`default_nettype wire
